/* File: hdl/usart_pkg.sv */
// constants, register map and carrier types for the synchronous usart block
//
// Function
// R1: software enables async nine-bit address-detect reception
// R2: address detect drops data bytes from buffer
// R3: software clears address detect once addressed
// R4: receive completion sets flag; interrupt needs enable
// R5: software reads status before received byte
// R6: errors cleared when continuous receive cleared; code clears only overrun, framing follows the queued word
// R7: sync mode bit4 tx; port enable bit7
// R8: master mode is half duplex
// R9: clock source bit7 selects master clock drive
// R10: shifter loads only after last bit sent
// R11: buffer to shifter one cycle, sets flag
// R12: empty flag ignores enable; cleared by write
// R13: shifter empty bit read-only, no interrupt
// R14: transmission starts on rising clock after data
// R15: data stable around falling shift clock edge
// R16: baud generator reset while all enables clear
// R17: buffer-then-enable starts; back-to-back supported
// R18: clearing transmit enable aborts, releases pins
// R19: receive enable aborts tx, releases data line
// R20: single receive self-clears, transmit resumes
// R21: ninth bit copied at moment of transfer
// R22: software sequence for master transmission setup
// R23: receive buffer is two-deep queue
// R24: ninth bit set marks an address byte
package usart_pkg;
  // register offsets
  localparam logic [7:0] addr_interrupt_control = 8'h0b;
  localparam logic [7:0] addr_peripheral_flags  = 8'h0c;
  localparam logic [7:0] addr_receive_status    = 8'h18;
  localparam logic [7:0] addr_transmit_buffer   = 8'h19;
  localparam logic [7:0] addr_receive_buffer    = 8'h1a;
  localparam logic [7:0] addr_peripheral_enable = 8'h8c;
  localparam logic [7:0] addr_transmit_status   = 8'h98;
  localparam logic [7:0] addr_baud_divisor      = 8'h99;
  // transmit_status_control fields
  localparam int tsc_clock_source_master  = 7;
  localparam int tsc_transmit_ninth_enable = 6;
  localparam int tsc_transmit_enable      = 5;
  localparam int tsc_clocked_mode_select  = 4;
  localparam int tsc_high_speed_baud      = 2;
  localparam int tsc_shift_register_empty = 1;
  localparam int tsc_transmit_ninth_value = 0;
  // receive_status_control fields
  localparam int rsc_port_enable          = 7;
  localparam int rsc_receive_ninth_enable = 6;
  localparam int rsc_single_receive       = 5;
  localparam int rsc_continuous_receive   = 4;
  localparam int rsc_address_detect       = 3;
  localparam int rsc_framing_error        = 2;
  localparam int rsc_overrun_error        = 1;
  localparam int rsc_receive_ninth_value  = 0;
  // flag and enable positions
  localparam int pf_receive_ready         = 5;
  localparam int pf_transmit_empty        = 4;
  localparam int ic_global_irq_enable     = 7;
  localparam int ic_peripheral_irq_enable = 6;
  // reset values
  localparam logic [7:0] reset_transmit_status = 8'h02;
  localparam logic [7:0] reset_zero            = 8'h00;
  // writable masks
  localparam logic [7:0] mask_transmit_status  = 8'hf5;
  localparam logic [7:0] mask_receive_status   = 8'hf8;
  // bits per word without ninth bit
  localparam logic [3:0] word_bits             = 4'h8;
  // one received word with its status
  typedef struct packed {
    logic       ninth;
    logic       framing;
    logic [7:0] data;
  } rx_word_type;
  // register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_type;
endpackage : usart_pkg

/* File: hdl/usart_sync.sv */
// synchronous master transmitter with address-detect receive path
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module usart_sync
  import usart_pkg::*;
#(
  parameter int depth = 2                         // receive queue depth
)(
  input  wire logic                  clk_i,       // 100 mhz core clock
  input  wire logic                  rst_i,       // synchronous reset
  input  wire usart_pkg::bus_req_type bus_i,      // register request
  output logic [7:0]                 rdata_o,     // read data, next cycle
  input  wire logic                  rx_valid_i,  // async receiver word done
  input  wire usart_pkg::rx_word_type rx_word_i,  // async received word
  input  wire logic                  clk_line_i,  // shift clock pin in
  output logic                       clk_line_o,  // shift clock pin out
  output logic                       clk_line_oe_o, // shift clock drive
  input  wire logic                  data_line_i, // shift data pin in
  output logic                       data_line_o, // shift data pin out
  output logic                       data_line_oe_o, // shift data drive
  output logic                       irq_o        // interrupt request
);
  import usart_pkg::*;

  // register storage
  logic [7:0] tsc_reg;          // transmit_status_control writable part
  logic [7:0] rsc_reg;          // receive_status_control writable part
  logic [7:0] ic_reg;           // interrupt_control
  logic [7:0] pe_reg;           // peripheral_enables
  logic [7:0] baud_reg;         // baud_divisor
  logic [7:0] txbuf_reg;        // transmit_buffer
  logic       tx_empty_reg;     // transmit_buffer_empty_flag
  logic       overrun_reg;      // overrun error
  logic [7:0] rdata_reg;        // registered read data
  // transmitter
  logic [8:0] tsr_reg;          // transmit_shifter
  logic [3:0] bits_reg;         // bits left in shifter
  logic       tsr_full_reg;     // shifter busy
  logic       tx_started_reg;   // first bit of the word is on the line
  // baud generator and clock line
  logic [7:0] brg_reg;          // divider counter
  logic       sck_reg;          // internal shift clock level
  // receive queue
  rx_word_type q_mem [depth];   // queued words
  logic [1:0] q_cnt_reg;        // words held
  logic       q_rd_reg;         // read pointer
  logic       q_wr_reg;         // write pointer
  // pin synchronisers
  logic [1:0] ck_sync_reg;      // clock pin sync chain
  logic [1:0] dt_sync_reg;      // data pin sync chain
  logic       ck_seen_reg;      // last synced clock level

  // field decode
  wire sync_mode  = tsc_reg[tsc_clocked_mode_select];                 // see R7
  wire port_en    = rsc_reg[rsc_port_enable];                         // see R7
  wire master     = tsc_reg[tsc_clock_source_master];                 // see R9
  wire tx_en      = tsc_reg[tsc_transmit_enable];
  wire ninth_en   = tsc_reg[tsc_transmit_ninth_enable];
  wire continuous_receive_enable       = rsc_reg[rsc_continuous_receive];
  wire single_receive_enable       = rsc_reg[rsc_single_receive];
  wire rx_on      = continuous_receive_enable | single_receive_enable;
  wire addr_det   = rsc_reg[rsc_address_detect];
  wire brg_run    = tx_en | rx_on;                                    // see R16
  wire tx_active  = sync_mode & port_en & tx_en & ~rx_on;             // see R8, R19
  wire brg_tick   = brg_run & (brg_reg == baud_reg);
  wire sck_rise   = brg_tick & ~sck_reg;
  wire sck_fall   = brg_tick & sck_reg;
  wire wr_txbuf   = bus_i.wr & (bus_i.addr == addr_transmit_buffer);
  wire rd_rxbuf   = bus_i.rd & (bus_i.addr == addr_receive_buffer);
  wire q_empty    = (q_cnt_reg == 2'h0);
  wire q_full     = (q_cnt_reg == 2'(depth));
  // load shifter when it is empty and a word waits
  wire tsr_load   = tx_en & ~tsr_full_reg & ~tx_empty_reg;            // see R10, R17
  // shift out one bit per rising edge while transmitting
  wire tsr_shift  = tsr_full_reg & tx_active & sck_rise;              // see R14, R15
  // a rising edge with bits left puts the next one out
  wire bit_out    = tsr_shift & (bits_reg != 4'h0);
  // the rising edge after the last bit ends the word, so the last bit
  // is still driven around its falling edge
  wire tsr_last   = tsr_shift & (bits_reg == 4'h0);
  // address detect filter: ninth bit set means address
  wire rx_accept  = rx_valid_i & ~sync_mode & port_en & continuous_receive_enable & ~overrun_reg
                  & (~addr_det | rx_word_i.ninth);                    // see R2, R24
  wire q_push     = rx_accept & ~q_full;
  wire q_pop      = rd_rxbuf & ~q_empty;
  wire rx_ready   = ~q_empty;                                         // see R4
  rx_word_type q_head;
  assign q_head   = q_mem[q_rd_reg];

  // read mux
  logic [7:0] rd_mux;
  always_comb
  begin
    case (bus_i.addr)
      addr_interrupt_control: rd_mux = ic_reg;
      addr_peripheral_flags:  rd_mux = {2'b00, rx_ready, tx_empty_reg, 4'h0};
      addr_receive_status:    rd_mux = {rsc_reg[7:3], q_head.framing & rx_ready,
                                        overrun_reg, q_head.ninth & rx_ready}; // see R5
      addr_transmit_buffer:   rd_mux = txbuf_reg;
      addr_receive_buffer:    rd_mux = rx_ready ? q_head.data : 8'h00;
      addr_peripheral_enable: rd_mux = pe_reg;
      addr_transmit_status:   rd_mux = {tsc_reg[7:2], ~tsr_full_reg,
                                        tsc_reg[0]};                  // see R13
      addr_baud_divisor:      rd_mux = baud_reg;
      default:                rd_mux = 8'h00;
    endcase
  end

  // register writes and read data
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tsc_reg   <= reset_transmit_status & mask_transmit_status;
      rsc_reg   <= reset_zero;
      ic_reg    <= reset_zero;
      pe_reg    <= reset_zero;
      baud_reg  <= reset_zero;
      txbuf_reg <= reset_zero;
      rdata_reg <= reset_zero;
    end
    else
    begin
      rdata_reg <= bus_i.rd ? rd_mux : 8'h00;
      if (bus_i.wr)
      begin
        case (bus_i.addr)
          addr_interrupt_control: ic_reg    <= bus_i.wdata;
          addr_receive_status:    rsc_reg   <= bus_i.wdata & mask_receive_status;
          addr_transmit_buffer:   txbuf_reg <= bus_i.wdata;
          addr_peripheral_enable: pe_reg    <= bus_i.wdata;
          addr_transmit_status:   tsc_reg   <= bus_i.wdata & mask_transmit_status;
          addr_baud_divisor:      baud_reg  <= bus_i.wdata;
          default:                ;
        endcase
      end
      // single receive self-clears after its word in sync mode
      if (sync_mode & single_receive_enable & ~continuous_receive_enable & rx_valid_i)
        rsc_reg[rsc_single_receive] <= 1'b0;                          // see R20
    end
  end

  // transmit buffer empty flag: write clears, transfer sets
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tx_empty_reg <= 1'b1;
    else if (tsr_load)
      tx_empty_reg <= 1'b1;                                           // see R11, R12
    else if (wr_txbuf)
      tx_empty_reg <= 1'b0;                                           // see R12
  end

  // transmit shifter
  always_ff @(posedge clk_i)
  begin
    if (rst_i | ~tx_en)
    begin
      tsr_reg        <= 9'h000;                                       // see R18
      bits_reg       <= 4'h0;
      tsr_full_reg   <= 1'b0;
      tx_started_reg <= 1'b0;
    end
    else if (tsr_load)
    begin
      tsr_reg        <= {tsc_reg[tsc_transmit_ninth_value], txbuf_reg}; // see R21
      bits_reg       <= word_bits + {3'h0, ninth_en};
      tsr_full_reg   <= 1'b1;
      tx_started_reg <= 1'b0;
    end
    else if (tsr_last)
    begin
      // word done, shifter free for the next load
      tsr_full_reg   <= 1'b0;                                         // see R10
      tx_started_reg <= 1'b0;
    end
    else if (bit_out)
    begin
      tsr_reg        <= {1'b0, tsr_reg[8:1]};
      bits_reg       <= bits_reg - 4'h1;
      tx_started_reg <= 1'b1;
    end
  end

  // baud generator, held in reset while no enable is set
  always_ff @(posedge clk_i)
  begin
    if (rst_i | ~brg_run)
    begin
      brg_reg <= 8'h00;                                               // see R16
      sck_reg <= 1'b0;
    end
    else if (brg_tick)
    begin
      brg_reg <= 8'h00;
      sck_reg <= ~sck_reg;
    end
    else
      brg_reg <= brg_reg + 8'h01;
  end

  // data line bit change on rising edge, held through falling
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      data_line_o <= 1'b0;
    else if (bit_out)
      data_line_o <= tsr_reg[0];                                      // see R15
  end

  // receive queue, two deep
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q_cnt_reg <= 2'h0;
      q_rd_reg  <= 1'b0;
      q_wr_reg  <= 1'b0;
    end
    else
    begin
      if (q_push)
      begin
        q_mem[q_wr_reg] <= rx_word_i;                                 // see R23
        q_wr_reg        <= ~q_wr_reg;
      end
      if (q_pop)
        q_rd_reg <= ~q_rd_reg;
      q_cnt_reg <= q_cnt_reg + {1'b0, q_push} - {1'b0, q_pop};
    end
  end

  // overrun error, cleared by dropping continuous receive
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      overrun_reg <= 1'b0;
    else if (rx_accept & q_full)
      overrun_reg <= 1'b1;
    else if (~continuous_receive_enable)
      overrun_reg <= 1'b0;                                            // see R6
  end

  // pin synchronisers, only the second stage is read
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ck_sync_reg <= 2'b00;
      dt_sync_reg <= 2'b00;
      ck_seen_reg <= 1'b0;
    end
    else
    begin
      ck_sync_reg <= {ck_sync_reg[0], clk_line_i};
      dt_sync_reg <= {dt_sync_reg[0], data_line_i};
      ck_seen_reg <= ck_sync_reg[1];
    end
  end

  // pin drive
  assign clk_line_o     = sck_reg;
  assign clk_line_oe_o  = sync_mode & port_en & master & brg_run;     // see R9, R19
  // drive only from the first bit on, so no stale level meets a falling edge
  assign data_line_oe_o = tx_active & tsr_full_reg & tx_started_reg;  // see R18, R19
  assign rdata_o        = rdata_reg;
  // interrupt gating
  assign irq_o = ic_reg[ic_global_irq_enable] & ic_reg[ic_peripheral_irq_enable]
               & ((rx_ready & pe_reg[pf_receive_ready])               // see R4
               |  (tx_empty_reg & pe_reg[pf_transmit_empty]));
endmodule : usart_sync
`default_nettype wire

/* File: verif/usart_sync_chk.sv */
// port-level assertion checker for the synchronous usart block
`timescale 1ns/10ps
`default_nettype none
module usart_sync_chk
  import usart_pkg::*;
#(
  parameter int depth = 2                          // receive queue depth
)(
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire usart_pkg::bus_req_type  bus_i,
  input wire logic [7:0]              rdata_o,
  input wire logic                    clk_line_o,
  input wire logic                    clk_line_oe_o,
  input wire logic                    data_line_o,
  input wire logic                    data_line_oe_o,
  input wire logic                    irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // register writes decoded once for the properties below
  wire tsc_wr = bus_i.wr && bus_i.addr == addr_transmit_status;
  wire rsc_wr = bus_i.wr && bus_i.addr == addr_receive_status;
  property p_tsc_reserved;
    bus_i.rd && bus_i.addr == addr_transmit_status |=> rdata_o[3] == 1'b0;
  endproperty
  a_tsc_reserved: assert property (p_tsc_reserved) else $error("reserved bit read high");
  property p_flags_reserved;
    bus_i.rd && bus_i.addr == addr_peripheral_flags |=> rdata_o[7:6] == 2'h0 && rdata_o[3:0] == 4'h0;
  endproperty
  a_flags_reserved: assert property (p_flags_reserved) else $error("unused flag bits set");
  property p_sync_off;
    tsc_wr && !bus_i.wdata[4] |-> ##[1:2] !data_line_oe_o;
  endproperty
  a_sync_off: assert property (p_sync_off) else $error("data driven outside clocked mode");
  property p_master_off;
    tsc_wr && bus_i.wdata[4] && !bus_i.wdata[7] |-> ##[1:2] !clk_line_oe_o;
  endproperty
  a_master_off: assert property (p_master_off) else $error("clock driven without master");
  property p_transmit_enable_off;
    tsc_wr && !bus_i.wdata[5] |-> ##[1:2] !data_line_oe_o;
  endproperty
  a_transmit_enable_off: assert property (p_transmit_enable_off) else $error("data held after abort");
  property p_port_off;
    rsc_wr && !bus_i.wdata[7] |-> ##[1:2] !data_line_oe_o && !clk_line_oe_o;
  endproperty
  a_port_off: assert property (p_port_off) else $error("pins driven with port off");
  property p_rx_abort;
    rsc_wr && bus_i.wdata[7] && (bus_i.wdata[5] || bus_i.wdata[4]) |-> ##[1:2] !data_line_oe_o;
  endproperty
  a_rx_abort: assert property (p_rx_abort) else $error("data not released for receive");
  property p_stable_fall;
    $fell(clk_line_o) && data_line_oe_o && $past(data_line_oe_o) |-> $stable(data_line_o);
  endproperty
  a_stable_fall: assert property (p_stable_fall) else $error("data moved at falling clock");
  c_tx_start: cover property (tsc_wr && bus_i.wdata[5]);
  c_bit_out: cover property ($fell(clk_line_o) && data_line_oe_o);
  c_irq: cover property (irq_o);
endmodule : usart_sync_chk
bind usart_sync usart_sync_chk #(.depth(depth)) usart_sync_chk_i (.clk_i(clk_i), .rst_i(rst_i),
  .bus_i(bus_i), .rdata_o(rdata_o), .clk_line_o(clk_line_o), .clk_line_oe_o(clk_line_oe_o),
  .data_line_o(data_line_o), .data_line_oe_o(data_line_oe_o), .irq_o(irq_o));
`default_nettype wire

/* File: verif/sync_peer.sv */
// behavioural synchronous peer capturing words from the shift lines
`timescale 1ns/10ps
`default_nettype none
module sync_peer
(
  input wire logic clk_line_i,                     // resolved shift clock
  input wire logic data_line_i,                    // resolved shift data
  input wire logic drv_i,                          // data line driven by the device
  input wire logic nine_i                          // nine bits per word
);
  logic [8:0] shift_reg = 9'h000;                  // bits so far, lsb first
  int         bit_cnt = 0;                         // bits in current word
  logic [8:0] words[$];                            // finished words
  // a released data line ends any partial word
  always @(negedge drv_i) bit_cnt = 0;
  // sample at the falling clock edge, where the data is settled
  always @(negedge clk_line_i)
  begin
    if (drv_i)
    begin
      shift_reg = {data_line_i, shift_reg[8:1]};
      bit_cnt++;
      if (bit_cnt == (nine_i ? 9 : 8))
      begin
        words.push_back(nine_i ? shift_reg : {1'b0, shift_reg[8:1]});
        bit_cnt = 0;
      end
    end
  end
endmodule : sync_peer
`default_nettype wire

/* File: verif/testbench.sv */
// self-checking bench for the synchronous usart block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import usart_pkg::*;
  logic        clk_i, rst_i, rx_valid_i, nine, clk_hold, data_hold;
  bus_req_type bus_i;
  rx_word_type rx_word_i;
  logic [7:0]  rdata_o, v;
  logic        clk_line_o, clk_line_oe_o, data_line_o, data_line_oe_o, irq_o;
  wire         clk_wire, data_wire;
  int          n_mismatch = 0;
  int          n_compared = 0;
  usart_sync usart_sync_i (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .rx_valid_i(rx_valid_i), .rx_word_i(rx_word_i), .clk_line_i(clk_wire),
    .clk_line_o(clk_line_o), .clk_line_oe_o(clk_line_oe_o), .data_line_i(data_wire),
    .data_line_o(data_line_o), .data_line_oe_o(data_line_oe_o), .irq_o(irq_o));
  sync_peer sync_peer_i (.clk_line_i(clk_wire), .data_line_i(data_wire),
    .drv_i(data_line_oe_o), .nine_i(nine));
  // released lines show the inverse of their last driven level
  assign clk_wire  = clk_line_oe_o ? clk_line_o : ~clk_hold;
  assign data_wire = data_line_oe_o ? data_line_o : ~data_hold;
  always @(posedge clk_i)
  begin
    if (clk_line_oe_o) clk_hold <= clk_line_o;
    if (data_line_oe_o) data_hold <= data_line_o;
  end
  // 100 mhz core clock
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus_i.wr <= 1'b0;
  endtask : wr
  // read, then compare the masked answer
  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk_i);
    bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus_i.rd <= 1'b0;
    #1 v = rdata_o;
    check({1'b0, v & m}, {1'b0, e});
  endtask : rchk
  // one word from the asynchronous receiver
  task automatic rx(input logic n, input logic [7:0] d);
    @(posedge clk_i);
    rx_valid_i <= 1'b1;
    rx_word_i <= '{ninth: n, framing: 1'b0, data: d};
    @(posedge clk_i);
    rx_valid_i <= 1'b0;
  endtask : rx
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : settle
  task automatic wait_words(input int n);
    repeat (800) if (sync_peer_i.words.size() < n) @(posedge clk_i);
  endtask : wait_words
  task automatic report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  // watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    #200000;
    n_mismatch++;
    report_and_stop();
  end
  initial
  begin
    rst_i = 1'b1;
    bus_i = '0;
    rx_valid_i = 1'b0;
    rx_word_i = '0;
    nine = 1'b0;
    clk_hold = 1'b0;
    data_hold = 1'b0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(addr_transmit_status, 8'hff, 8'h02);
    rchk(addr_baud_divisor, 8'hff, 8'h00);
    rchk(8'h55, 8'hff, 8'h00);
    wr(addr_transmit_status, 8'h10);
    wr(addr_transmit_status, 8'h00);
    rchk(addr_transmit_status, 8'h02, 8'h02);
    $display("test reset done");
    wr(addr_receive_status, 8'hd8);
    wr(addr_peripheral_enable, 8'h20);
    wr(addr_interrupt_control, 8'hc0);
    rx(1'b0, 8'h11);
    rchk(addr_peripheral_flags, 8'h20, 8'h00);
    rx(1'b1, 8'h22);
    rchk(addr_peripheral_flags, 8'h20, 8'h20);
    check(irq_o, 1'b1);
    wr(addr_peripheral_enable, 8'h00);
    rchk(addr_receive_status, 8'h01, 8'h01);
    check(irq_o, 1'b0);
    rchk(addr_receive_buffer, 8'hff, 8'h22);
    wr(addr_receive_status, 8'hd0);
    rx(1'b0, 8'h33);
    rx(1'b0, 8'h44);
    rx(1'b1, 8'h55);
    rchk(addr_receive_status, 8'h02, 8'h02);
    rchk(addr_receive_buffer, 8'hff, 8'h33);
    rchk(addr_receive_buffer, 8'hff, 8'h44);
    rchk(addr_peripheral_flags, 8'h20, 8'h00);
    wr(addr_receive_status, 8'hc0);
    rchk(addr_receive_status, 8'h06, 8'h00);
    wr(addr_receive_status, 8'h00);
    $display("test receive done");
    wr(addr_baud_divisor, 8'h03);
    wr(addr_receive_status, 8'h80);
    wr(addr_transmit_status, 8'hb0);
    wr(addr_transmit_buffer, 8'ha5);
    wr(addr_transmit_buffer, 8'h3c);
    rchk(addr_peripheral_flags, 8'h10, 8'h00);
    wait_words(2);
    check(sync_peer_i.words.pop_front(), 9'h0a5);
    check(sync_peer_i.words.pop_front(), 9'h03c);
    settle(10);
    rchk(addr_transmit_status, 8'h02, 8'h02);
    wr(addr_peripheral_flags, 8'h00);
    rchk(addr_peripheral_flags, 8'h10, 8'h10);
    nine = 1'b1;
    wr(addr_transmit_status, 8'hd1);
    wr(addr_transmit_buffer, 8'h5a);
    wr(addr_transmit_status, 8'hf1);
    wait_words(1);
    check(sync_peer_i.words.pop_front(), 9'h15a);
    nine = 1'b0;
    $display("test transmit done");
    wr(addr_transmit_status, 8'hb0);
    wr(addr_transmit_buffer, 8'hff);
    settle(30);
    wr(addr_receive_status, 8'ha0);
    settle(2);
    check(data_line_oe_o, 1'b0);
    check(clk_line_oe_o, 1'b1);
    rx(1'b0, 8'h77);
    settle(2);
    check(data_line_oe_o, 1'b1);
    rchk(addr_receive_status, 8'h20, 8'h00);
    wr(addr_transmit_status, 8'h90);
    settle(2);
    check(data_line_oe_o, 1'b0);
    check(clk_line_oe_o, 1'b0);
    $display("test abort done");
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
